// ===== src/gpe_regs.svh
`ifndef GPE_REGS_SVH
`define GPE_REGS_SVH
`define GPE_ADDR_DATA 3'h0
`define GPE_ADDR_DIR 3'h1
`define GPE_ADDR_OPT 3'h2
`define GPE_ADDR_MISC 3'h3
`define GPE_RESET_VAL 8'h00
`define GPE_MISC_IS1_LO 3
`define GPE_MISC_IS0_LO 1
`endif

// ===== src/gpe_pkg.sv
package gpe_pkg;
  typedef enum logic [1:0] {
    GPE_SENS_FALL_LOW = 2'b00,
    GPE_SENS_RISE = 2'b01,
    GPE_SENS_FALL = 2'b10,
    GPE_SENS_BOTH = 2'b11
  } gpe_sens_t;
endpackage

// ===== src/gpe_port.sv
`timescale 1ns/1ps
`include "gpe_regs.svh"
module gpe_port
  import gpe_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_en_o,
  input wire logic [7:0] alt_en_i,
  input wire logic [7:0] alt_out_en_i,
  input wire logic [7:0] alt_out_i,
  input wire logic [7:0] alt_pp_i,
  output logic [7:0] alt_in_o,
  input wire logic [7:0] bank0_mask_i,
  input wire logic [1:0] vec_fetch_i,
  output logic [1:0] irq_o
);
  // ==========================================
  // registers
  logic [7:0] data_q, dir_q, opt_q, misc_q;
  logic [7:0] pin_s1_q, pin_q;
  logic [1:0] src_prev_q, irq_q;
  logic [7:0] rdata_q;

  function automatic logic sens_hit(input logic [1:0] s, input logic prev, input logic cur);
    case (s)
      GPE_SENS_FALL_LOW: sens_hit = !cur;
      GPE_SENS_RISE: sens_hit = !prev && cur;
      GPE_SENS_FALL: sens_hit = prev && !cur;
      GPE_SENS_BOTH: sens_hit = prev != cur;
      default: sens_hit = 1'b0;
    endcase
  endfunction

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      data_q <= `GPE_RESET_VAL;
      dir_q <= `GPE_RESET_VAL;
      opt_q <= `GPE_RESET_VAL;
      misc_q <= `GPE_RESET_VAL;
    end else if (en_i && wr_i) begin
      case (addr_i)
        `GPE_ADDR_DATA: data_q <= wdata_i;
        `GPE_ADDR_DIR: dir_q <= wdata_i;
        `GPE_ADDR_OPT: opt_q <= wdata_i;
        `GPE_ADDR_MISC: misc_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // ==========================================
  // pin synchroniser; first stage feeds only the second
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q <= 8'h00;
      pin_q <= 8'h00;
    end else if (en_i) begin
      pin_s1_q <= pin_i;
      pin_q <= pin_s1_q;
    end
  end

  // ==========================================
  // pad control, per bit n
  logic [7:0] alt_drive, out_mode, push_pull, drive_val;
  always_comb begin
    alt_drive = alt_en_i & alt_out_en_i;
    out_mode = alt_drive | (~alt_en_i & dir_q);
    push_pull = (alt_drive & alt_pp_i) | (~alt_drive & opt_q);
    drive_val = (alt_drive & alt_out_i) | (~alt_drive & data_q);
    pin_o = drive_val;
    pin_oe_o = out_mode & (push_pull | ~drive_val);
    pullup_en_o = ~out_mode & ~alt_en_i & opt_q;
    alt_in_o = (dir_q & data_q) | (~dir_q & pin_q);
  end

  // ==========================================
  // register read, data one cycle after strobe
  logic [7:0] data_rd;
  always_comb begin
    data_rd = (dir_q & data_q) | (~dir_q & ~alt_drive & pin_q) | (~dir_q & alt_drive & alt_out_i);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (en_i) begin
      if (rd_i) begin
        case (addr_i)
          `GPE_ADDR_DATA: rdata_q <= data_rd;
          `GPE_ADDR_DIR: rdata_q <= dir_q;
          `GPE_ADDR_OPT: rdata_q <= opt_q;
          `GPE_ADDR_MISC: rdata_q <= misc_q;
          default: rdata_q <= 8'h00;
        endcase
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
  assign rdata_o = rdata_q;

  // ==========================================
  // external interrupt sources; non-interrupt pins read as 1 in the AND
  logic [7:0] irq_pin;
  logic [1:0] src, hit, sens_wr;
  always_comb begin
    irq_pin = ~dir_q & opt_q;
    src[0] = &(pin_q | ~(irq_pin & bank0_mask_i));
    src[1] = &(pin_q | ~(irq_pin & ~bank0_mask_i));
    hit[0] = (|(irq_pin & bank0_mask_i)) && sens_hit(misc_q[`GPE_MISC_IS0_LO +: 2], src_prev_q[0], src[0]);
    hit[1] = (|(irq_pin & ~bank0_mask_i)) && sens_hit(misc_q[`GPE_MISC_IS1_LO +: 2], src_prev_q[1], src[1]);
    sens_wr[0] = wr_i && addr_i == `GPE_ADDR_MISC && wdata_i[`GPE_MISC_IS0_LO +: 2] != misc_q[`GPE_MISC_IS0_LO +: 2];
    sens_wr[1] = wr_i && addr_i == `GPE_ADDR_MISC && wdata_i[`GPE_MISC_IS1_LO +: 2] != misc_q[`GPE_MISC_IS1_LO +: 2];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      src_prev_q <= 2'b11;
    end else if (en_i) begin
      src_prev_q <= src;
    end
  end

  // a new event in a fetch cycle wins; a sensitivity change always clears
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      irq_q <= 2'b00;
    end else if (en_i) begin
      irq_q <= (hit | (irq_q & ~vec_fetch_i)) & ~sens_wr;
    end
  end
  assign irq_o = irq_q;

  // ==========================================
  // checks on reset and pad control
  a_rst_zero: assert property (@(posedge clock_i)
    $fell(rst_i)
    |-> dir_q == 8'h00 && opt_q == 8'h00 && data_q == 8'h00 && misc_q == 8'h00 && irq_o == 2'b00)
    else $error("registers not zero after reset");
  a_oe_input: assert property (@(posedge clock_i) disable iff (rst_i)
    (alt_en_i == 8'h00)
    |-> ((pin_oe_o & ~dir_q) == 8'h00))
    else $error("input pin driven");
  a_od_high: assert property (@(posedge clock_i) disable iff (rst_i)
    (alt_en_i == 8'h00)
    |-> ((pin_oe_o & dir_q & ~opt_q & data_q) == 8'h00))
    else $error("open drain drives high");
  a_pp_drive: assert property (@(posedge clock_i) disable iff (rst_i)
    (alt_en_i == 8'h00)
    |-> ((pin_oe_o & dir_q & opt_q) == (dir_q & opt_q)))
    else $error("push-pull not driven");
  a_od_low: assert property (@(posedge clock_i) disable iff (rst_i)
    (alt_en_i == 8'h00)
    |-> ((dir_q & ~data_q & ~pin_oe_o) == 8'h00))
    else $error("output low not driven");
  a_pin_latch: assert property (@(posedge clock_i) disable iff (rst_i)
    (alt_en_i == 8'h00)
    |-> (((pin_o ^ data_q) & dir_q) == 8'h00))
    else $error("pin value differs from latch");
  a_pullup_cfg: assert property (@(posedge clock_i) disable iff (rst_i)
    (alt_en_i == 8'h00)
    |-> (pullup_en_o == (~dir_q & opt_q)))
    else $error("pull-up configuration wrong");
  a_pullup_drive: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1
    |-> ((pullup_en_o & pin_oe_o) == 8'h00))
    else $error("pull-up on a driven pin");

  // checks on alternate functions
  a_alt_force: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1
    |-> ((alt_drive & ~pin_oe_o & ~alt_out_i) == 8'h00))
    else $error("alternate low not driven");
  a_alt_pp: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1
    |-> ((alt_drive & alt_pp_i & ~pin_oe_o) == 8'h00))
    else $error("alternate push-pull not driven");
  a_alt_od: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1
    |-> ((alt_drive & ~alt_pp_i & alt_out_i & pin_oe_o) == 8'h00))
    else $error("alternate open drain drives high");
  a_alt_value: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1
    |-> ((alt_drive & (pin_o ^ alt_out_i)) == 8'h00))
    else $error("alternate value not on pin");
  a_alt_no_pull: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1
    |-> ((alt_en_i & pullup_en_o) == 8'h00))
    else $error("pull-up on alternate pin");
  a_alt_in_latch: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1
    |-> ((alt_en_i & dir_q & (alt_in_o ^ data_q)) == 8'h00))
    else $error("peripheral input not from latch");
  a_alt_in_pin: assert property (@(posedge clock_i) disable iff (rst_i)
    1'b1
    |-> ((~dir_q & (alt_in_o ^ pin_q)) == 8'h00))
    else $error("peripheral input not from pin");

  // checks on the register port
  a_wr_data_lat: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && wr_i && addr_i == `GPE_ADDR_DATA
    |=> data_q == $past(wdata_i))
    else $error("data latch missed write");
  a_wr_dir: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && wr_i && addr_i == `GPE_ADDR_DIR
    |=> dir_q == $past(wdata_i))
    else $error("direction missed write");
  a_wr_opt: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && wr_i && addr_i == `GPE_ADDR_OPT
    |=> opt_q == $past(wdata_i))
    else $error("option missed write");
  a_rd_dir: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && rd_i && addr_i == `GPE_ADDR_DIR
    |=> rdata_o == $past(dir_q))
    else $error("direction readback wrong");
  a_rd_opt: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && rd_i && addr_i == `GPE_ADDR_OPT
    |=> rdata_o == $past(opt_q))
    else $error("option readback wrong");
  a_rd_misc: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && rd_i && addr_i == `GPE_ADDR_MISC
    |=> rdata_o == $past(misc_q))
    else $error("misc readback wrong");
  a_rd_data_out: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && rd_i && addr_i == `GPE_ADDR_DATA
    |=> ((rdata_o ^ $past(data_q)) & $past(dir_q)) == 8'h00)
    else $error("output readback not latch");
  a_rd_data_in: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && rd_i && addr_i == `GPE_ADDR_DATA && alt_en_i == 8'h00
    |=> ((rdata_o ^ $past(pin_q)) & ~$past(dir_q)) == 8'h00)
    else $error("input readback not pin");
  a_rd_alt_out: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && rd_i && addr_i == `GPE_ADDR_DATA
    |=> (($past(alt_drive) & ~$past(dir_q)) & (rdata_o ^ $past(alt_out_i))) == 8'h00)
    else $error("alternate output not read back");
  a_rd_idle: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && !rd_i
    |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_freeze: assert property (@(posedge clock_i) disable iff (rst_i)
    !en_i
    |=> $stable(dir_q) && $stable(data_q) && $stable(irq_o) && $stable(rdata_o))
    else $error("state moved with enable low");

  // checks on external interrupts and the pin synchroniser
  a_sens_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && sens_wr[0]
    |=> !irq_o[0])
    else $error("sensitivity change left request");
  a_sens_clear1: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && sens_wr[1]
    |=> !irq_o[1])
    else $error("sensitivity change left request");
  a_fetch_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && vec_fetch_i[1] && !hit[1]
    |=> !irq_o[1])
    else $error("fetch left request");
  a_fetch_clear0: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && vec_fetch_i[0] && !hit[0]
    |=> !irq_o[0])
    else $error("fetch left request");
  a_irq_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && irq_o[0] && !vec_fetch_i[0] && !sens_wr[0]
    |=> irq_o[0])
    else $error("request lost without clear");
  a_irq_set: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && hit[0] && !sens_wr[0]
    |=> irq_o[0])
    else $error("event did not raise request");
  a_irq_set1: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && hit[1] && !sens_wr[1]
    |=> irq_o[1])
    else $error("event did not raise request");
  a_irq_no_src: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && !irq_o[0] && (irq_pin & bank0_mask_i) == 8'h00
    |=> !irq_o[0])
    else $error("request without interrupt pin");
  a_and_mask: assert property (@(posedge clock_i) disable iff (rst_i)
    (irq_pin & bank0_mask_i & ~pin_q) != 8'h00
    |-> !src[0])
    else $error("low pin did not mask source");
  a_and_mask1: assert property (@(posedge clock_i) disable iff (rst_i)
    (irq_pin & ~bank0_mask_i & ~pin_q) != 8'h00
    |-> !src[1])
    else $error("low pin did not mask source");
  a_level_low: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && misc_q[`GPE_MISC_IS0_LO +: 2] == GPE_SENS_FALL_LOW && (irq_pin & bank0_mask_i) != 8'h00
      && !src[0] && !sens_wr[0]
    |=> irq_o[0])
    else $error("low level did not raise request");
  a_rise_only: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && misc_q[`GPE_MISC_IS0_LO +: 2] == GPE_SENS_RISE && !irq_o[0] && !(!src_prev_q[0] && src[0])
    |=> !irq_o[0])
    else $error("request without rising edge");
  a_fall_only: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i && misc_q[`GPE_MISC_IS0_LO +: 2] == GPE_SENS_FALL && !irq_o[0] && !(src_prev_q[0] && !src[0])
    |=> !irq_o[0])
    else $error("request without falling edge");
  a_sync_delay: assert property (@(posedge clock_i) disable iff (rst_i)
    en_i ##1 en_i
    |-> pin_q == $past(pin_i, 2))
    else $error("synchroniser delay wrong");

  // scenarios worth seeing
  c_irq0: cover property (@(posedge clock_i) disable iff (rst_i) $rose(irq_o[0]));
  c_irq1_fetch: cover property (@(posedge clock_i) disable iff (rst_i) irq_o[1] ##1 vec_fetch_i[1]);
  c_alt_out: cover property (@(posedge clock_i) disable iff (rst_i) alt_drive != 8'h00);
  c_fetch_set: cover property (@(posedge clock_i) disable iff (rst_i) vec_fetch_i[0] && hit[0]);
  c_freeze: cover property (@(posedge clock_i) disable iff (rst_i) !en_i && wr_i);
endmodule

// ===== testbench/gpe_pad_model.sv
`timescale 1ns/1ps
// ==========
// pads: chip drive wins, then outside drive, then pull-up
module gpe_pad_model (
  input wire logic clock_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] ext_oe_i,
  input wire logic [7:0] ext_v_i,
  output logic [7:0] pad_o
);
  // floating pads toggle so a stale level never passes
  logic [7:0] flt_q = 8'h55;
  always_ff @(posedge clock_i) begin
    flt_q <= ~flt_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_o[i] = oe_i[i] ? out_i[i] : ext_oe_i[i] ? ext_v_i[i] : pu_i[i] ? 1'b1 : flt_q[i];
    end
  end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock_i, rst_i, wr_i, rd_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rdata_o, pin_i, pin_o, pin_oe_o, pullup_en_o, alt_en_i, alt_out_en_i;
  logic [7:0] alt_out_i, alt_pp_i, alt_in_o, bank0_mask_i, ext_oe, ext_v;
  logic [1:0] vec_fetch_i, irq_o;
  int miscompares, num_checks;
  logic en;
  gpe_port gpe_port_inst (.clock_i(clock_i), .rst_i(rst_i), .en_i(en), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pullup_en_o(pullup_en_o), .alt_en_i(alt_en_i), .alt_out_en_i(alt_out_en_i), .alt_out_i(alt_out_i),
    .alt_pp_i(alt_pp_i), .alt_in_o(alt_in_o), .bank0_mask_i(bank0_mask_i), .vec_fetch_i(vec_fetch_i),
    .irq_o(irq_o));
  gpe_pad_model gpe_pad_model_inst (.clock_i(clock_i), .oe_i(pin_oe_o), .out_i(pin_o), .pu_i(pullup_en_o),
    .ext_oe_i(ext_oe), .ext_v_i(ext_v), .pad_o(pin_i));
  // ==========
  // bus tasks
  initial begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk("rdata", e, rdata_o);
  endtask
  task automatic fetch(input logic [1:0] v);
    @(posedge clock_i);
    vec_fetch_i <= v;
    @(posedge clock_i);
    vec_fetch_i <= 2'b00;
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i, alt_en_i, alt_out_en_i, alt_out_i, alt_pp_i} = '0;
    {bank0_mask_i, ext_oe, ext_v, vec_fetch_i} = {8'hff, 8'hff, 8'h00, 2'b00};
    rst_i = 1'b1;
    en = 1'b1;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 4; a++) rd(a[2:0], 8'h00);
    rd(3'h5, 8'h00);
    ext_v <= 8'ha5;
    w(4);
    rd(3'h0, 8'ha5);
    wr(3'h0, 8'h3c);
    w(1);
    chk("oe_in", 8'h00, pin_oe_o);
    ext_oe <= 8'h00;
    wr(3'h2, 8'h0f);
    wr(3'h1, 8'hff);
    w(1);
    chk("oe_out", 8'hcf, pin_oe_o);
    chk("pin_out", 8'h0c, pin_o & pin_oe_o);
    rd(3'h0, 8'h3c);
    ext_oe <= 8'hff;
    wr(3'h1, 8'h00);
    w(1);
    chk("pullup", 8'h0f, pullup_en_o);
    wr(3'h0, 8'h02);
    wr(3'h2, 8'h0c);
    {alt_en_i, alt_out_en_i, alt_out_i, alt_pp_i, ext_oe} <= {8'h03, 8'h01, 8'h01, 8'h01, 8'hfc};
    wr(3'h1, 8'h02);
    w(1);
    chk("alt_oe", 8'h01, pin_oe_o & 8'h03);
    chk("alt_in", 8'h02, alt_in_o & 8'h02);
    rd(3'h0, 8'ha7);
    {alt_en_i, ext_oe, ext_v} <= {8'h00, 8'hff, 8'h00};
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h03);
    wr(3'h3, 8'h02);
    ext_v <= 8'h01;
    w(5);
    chk("irq_and", 8'h00, {6'h0, irq_o});
    ext_v <= 8'h03;
    w(5);
    chk("irq_rise", 8'h01, {6'h0, irq_o});
    fetch(2'b01);
    w(1);
    chk("irq_fetch", 8'h00, {6'h0, irq_o});
    wr(3'h3, 8'h04);
    ext_v <= 8'h01;
    w(5);
    chk("irq_fall", 8'h01, {6'h0, irq_o});
    wr(3'h3, 8'h02);
    w(1);
    chk("irq_sens", 8'h00, {6'h0, irq_o});
    wr(3'h3, 8'h00);
    fetch(2'b01);
    w(3);
    chk("irq_low", 8'h01, {6'h0, irq_o});
    wr(3'h3, 8'h06);
    ext_v <= 8'h03;
    w(5);
    chk("irq_both", 8'h01, {6'h0, irq_o});
    bank0_mask_i <= 8'hfe;
    wr(3'h3, 8'h08);
    ext_v <= 8'h02;
    w(4);
    ext_v <= 8'h03;
    w(5);
    chk("irq_vec1", 8'h02, {6'h0, irq_o});
    fetch(2'b10);
    w(1);
    chk("irq_fetch1", 8'h00, {6'h0, irq_o});
    en <= 1'b0;
    wr(3'h1, 8'hff);
    en <= 1'b1;
    rd(3'h1, 8'h00);
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    miscompares++;
    print_verdict;
  end
endmodule
